// ### hdl/ebh_port.v
// Behaviour
// RULE_01: One 64-bit data bus and one 32-bit address bus for every transfer.
// RULE_02: Bus width 32 or 64; in 64-bit mode odd words use high half.
// RULE_03: Pipelined, acknowledge-controlled slow, and SDRAM protocols on the bus.
// RULE_04: High address bits decoded on chip into one select per bank.
// RULE_05: Device-to-host uses pipelined or slow; host-to-device uses pipelined only.
// RULE_06: Each host protocol has programmable idle, pipe depth and wait cycles; the slow protocol ignores its pipe depth field and uses its idle and wait cycles.
// RULE_07: Host gives start address and holds burst; device increments address.
// RULE_08: On back-off the device abandons, grants host and releases the bus.
// RULE_09: Distributed arbiter shares the bus among eight processors and a host.
// RULE_10: Peer ownership follows rotating priority, not fixed priority.
// RULE_11: Bus lock keeps ownership across read then write.
// RULE_12: Fairness forces a long-holding owner to give up the bus.
// RULE_13: SDRAM moves 32 or 64 bits per clock, per configured width.
// RULE_14: SDRAM: four banks of 64M words; 16M to 256M bit parts.
// RULE_15: Boot strap set: load program from byte-wide boot memory after reset.
// RULE_16: Each boot memory read inserts sixteen wait cycles.
// RULE_17: Boot memory select is the boot memory chip select while booting.
// RULE_18: Boot packs four bytes into each 32-bit word written internally.
// RULE_19: Boot space is byte addressed, 24 bits, outside the memory map.
// RULE_20: Burst address advances one bus-width word per accepted beat.
//
// The implementer's own choices: the Avalon-MM slave port and the register addresses.
`timescale 1ns/1ps
`include "ebh_consts.vh"
`default_nettype none
module ebh_port #(
   parameter [2:0] MY_ID = 3'h0,
   parameter [15:0] BOOT_WORDS = 16'h0100
) (
   // Clock and reset
   input wire i_clk_sys,
   input wire i_rst,
   // Avalon-MM configuration slave
   input wire [4:0] i_avs_address,
   input wire i_avs_read,
   input wire i_avs_write,
   input wire [31:0] i_avs_writedata,
   output reg [31:0] o_avs_readdata,
   output reg o_avs_waitrequest,
   // Core transfer request
   input wire i_tr_valid,
   input wire i_tr_write,
   input wire i_tr_dual,
   input wire [31:0] i_tr_addr,
   input wire [63:0] i_tr_wdata,
   output reg o_tr_done,
   output reg [63:0] o_tr_rdata,
   // External bus pins
   output reg [31:0] o_addr,
   input wire [63:0] i_data,
   output reg [63:0] o_data,
   output reg o_data_oe,
   output reg o_rd_n,
   output reg o_wr_n,
   input wire i_ack,
   output reg [1:0] o_ms_n,
   output reg [3:0] o_msd_n,
   output reg o_msh_n,
   output reg o_boot_memory_select_n,
   // Arbitration and host pins
   input wire [7:0] i_br_n,
   output reg o_br_n,
   input wire i_hbr_n,
   output reg o_host_bus_grant_n,
   input wire i_backoff_request_n,
   input wire i_burst_continue_n,
   input wire i_hst_wr_n,
   input wire [31:0] i_hst_addr,
   input wire i_boot_strap,
   // Internal memory write port
   output reg o_imem_we,
   output reg [31:0] o_imem_addr,
   output reg [63:0] o_imem_data,
   output reg [1:0] o_imem_wen
);
   localparam [6:0] S_INIT = 7'h01;
   localparam [6:0] S_BOOT = 7'h02;
   localparam [6:0] S_IDLE = 7'h04;
   localparam [6:0] S_REQ = 7'h08;
   localparam [6:0] S_XFER = 7'h10;
   localparam [6:0] S_GAP = 7'h20;
   localparam [6:0] S_HOLD = 7'h40;

   // All pins are sampled by a two-stage synchroniser; only stage two is read.
   localparam integer PW = 110;
   reg [PW-1:0] pin_m_q;
   reg [PW-1:0] pin_s_q;
   always @(posedge i_clk_sys or posedge i_rst) begin
      if (i_rst) begin
         pin_m_q <= {PW{1'b1}};
         pin_s_q <= {PW{1'b1}};
      end else begin
         pin_m_q <= {i_data, i_hst_addr, i_br_n, i_ack, i_backoff_request_n,
                     i_burst_continue_n, i_hbr_n, i_hst_wr_n, i_boot_strap};
         pin_s_q <= pin_m_q;
      end
   end
   wire [63:0] data_s = pin_s_q[109:46];
   wire [31:0] haddr_s = pin_s_q[45:14];
   wire [7:0] brn_s = pin_s_q[13:6];
   wire ack_s = pin_s_q[5];
   wire backoff_request_s = ~pin_s_q[4];
   wire burst_continue_s = ~pin_s_q[3];
   wire hbr_s = ~pin_s_q[2];
   wire hwr_s = ~pin_s_q[1];
   wire strap_s = pin_s_q[0];

   reg [3:0] ctrl_q;
   reg [11:0] pipe_q;
   reg [11:0] slow_q;
   reg [7:0] fair_q;
   reg [1:0] sdrc_q;
   wire bus64 = ctrl_q[`EBH_CTRL_BUS64];
   wire lock = ctrl_q[`EBH_CTRL_LOCK];

   // Distributed arbiter: every node computes the same winner from all requests.
   reg [6:0] st_q;
   reg br_q;
   reg yield_q;
   reg [2:0] last_q;
   reg [7:0] hold_q;
   reg [7:0] req;
   reg [2:0] win;
   reg found;
   integer k;
   always @* begin
      req = ~brn_s;
      req[MY_ID] = br_q & ~yield_q; // RULE_12
      win = last_q;
      found = 1'b0;
      // Search starts at the last owner, so it keeps the bus only while it asks.
      for (k = 0; k < 8; k = k + 1) begin
         if (!found && req[last_q + k[2:0]]) begin // RULE_10
            win = last_q + k[2:0];
            found = 1'b1;
         end
      end
   end
   wire any_req = |req;
   wire own = any_req && (win == MY_ID); // RULE_09
   wire others = |(req & ~(8'h01 << MY_ID));

   always @(posedge i_clk_sys or posedge i_rst) begin
      if (i_rst) begin
         last_q <= 3'h0;
         hold_q <= 8'h00;
         yield_q <= 1'b0;
      end else begin
         if (any_req) begin
            last_q <= win;
         end
         hold_q <= own ? hold_q + 8'h01 : 8'h00;
         if (ctrl_q[`EBH_CTRL_FAIR] && !lock && own && others && hold_q >= fair_q) begin
            yield_q <= 1'b1; // RULE_12
         end else if (any_req && win != MY_ID) begin
            yield_q <= 1'b0;
         end
      end
   end

   // Region decode of the transfer address.
   wire host_rgn = i_tr_addr[`EBH_HOST_BIT];
   wire sd_rgn = !host_rgn && i_tr_addr[`EBH_REGION] == `EBH_SD_REGION;
   wire ms_rgn = !host_rgn && i_tr_addr[`EBH_REGION] == `EBH_MS_REGION;
   wire use_slow = host_rgn && ctrl_q[`EBH_CTRL_SLOW]; // RULE_05
   wire [11:0] cfg = use_slow ? slow_q : pipe_q; // RULE_06
   reg [31:0] sd_mask;
   always @* begin
      case (sdrc_q) // RULE_14
         2'h0: sd_mask = 32'h0C07_FFFF;
         2'h1: sd_mask = 32'h0C1F_FFFF;
         2'h2: sd_mask = 32'h0C3F_FFFF;
         default: sd_mask = 32'h0C7F_FFFF;
      endcase
   end
   // SDRAM data returns after the pipe depth, which must also cover the pin synchroniser.
   wire [3:0] wait_ld = sd_rgn ? cfg[`EBH_CFG_DEPTH] : // RULE_13
      use_slow ? cfg[`EBH_CFG_WAIT] : cfg[`EBH_CFG_DEPTH] + cfg[`EBH_CFG_WAIT];

   reg [7:0] cnt_q;
   reg beat_q;
   reg slow_q_x;
   reg [23:0] boot_addr_q;
   reg [31:0] pack_q;
   reg [15:0] boot_words_q;
   reg boot_done_q;
   reg burst_q;
   reg [31:0] burst_addr_q;
   reg [31:0] cur_addr;
   wire [31:0] beat_addr = burst_q ? burst_addr_q : haddr_s;

   always @* begin
      cur_addr = i_tr_addr + {31'h0, beat_q};
      if (sd_rgn) begin
         cur_addr = cur_addr & sd_mask;
      end
   end

   always @(posedge i_clk_sys or posedge i_rst) begin
      if (i_rst) begin
         st_q <= S_INIT;
         cnt_q <= 8'h00;
         beat_q <= 1'b0;
         slow_q_x <= 1'b0;
         br_q <= 1'b0;
         o_br_n <= 1'b1;
         o_host_bus_grant_n <= 1'b1;
         o_addr <= 32'h0000_0000;
         o_data <= 64'h0000_0000_0000_0000;
         o_data_oe <= 1'b0;
         o_rd_n <= 1'b1;
         o_wr_n <= 1'b1;
         o_ms_n <= 2'h3;
         o_msd_n <= 4'hF;
         o_msh_n <= 1'b1;
         o_boot_memory_select_n <= 1'b1;
         o_tr_done <= 1'b0;
         o_tr_rdata <= 64'h0000_0000_0000_0000;
         o_imem_we <= 1'b0;
         o_imem_addr <= 32'h0000_0000;
         o_imem_data <= 64'h0000_0000_0000_0000;
         o_imem_wen <= 2'h0;
         boot_addr_q <= 24'h00_0000;
         pack_q <= 32'h0000_0000;
         boot_words_q <= 16'h0000;
         boot_done_q <= 1'b0;
         burst_q <= 1'b0;
         burst_addr_q <= 32'h0000_0000;
      end else begin
         o_tr_done <= 1'b0;
         o_imem_we <= 1'b0;
         o_br_n <= ~(br_q & ~yield_q);
         case (st_q)
            S_INIT: begin
               // The strap is caught once the synchroniser holds a clean value.
               cnt_q <= cnt_q + 8'h01;
               if (cnt_q == 8'h02) begin
                  cnt_q <= 8'h00;
                  st_q <= strap_s ? S_BOOT : S_IDLE; // RULE_15
                  boot_done_q <= !strap_s;
               end
            end
            S_BOOT: begin
               o_boot_memory_select_n <= 1'b0; // RULE_17
               o_rd_n <= 1'b0;
               o_addr <= {8'h00, boot_addr_q}; // RULE_19
               if (cnt_q != `EBH_BOOT_WAIT) begin
                  cnt_q <= cnt_q + 8'h01; // RULE_16
               end else begin
                  cnt_q <= 8'h00;
                  boot_addr_q <= boot_addr_q + 24'h00_0001;
                  pack_q <= {data_s[7:0], pack_q[31:8]};
                  if (boot_addr_q[1:0] == 2'h3) begin
                     o_imem_we <= 1'b1; // RULE_18
                     o_imem_addr <= {16'h0000, boot_words_q};
                     o_imem_data <= {32'h0000_0000, data_s[7:0], pack_q[31:8]};
                     o_imem_wen <= 2'h1;
                     boot_words_q <= boot_words_q + 16'h0001;
                     if (boot_words_q + 16'h0001 == BOOT_WORDS) begin
                        st_q <= S_IDLE;
                        boot_done_q <= 1'b1;
                        o_boot_memory_select_n <= 1'b1;
                        o_rd_n <= 1'b1;
                     end
                  end
               end
            end
            S_IDLE: begin
               br_q <= lock; // RULE_11
               if (hbr_s && !lock) begin
                  o_host_bus_grant_n <= 1'b0;
                  br_q <= 1'b0;
                  st_q <= S_HOLD;
               end else if (i_tr_valid) begin
                  br_q <= 1'b1;
                  beat_q <= 1'b0;
                  st_q <= S_REQ;
               end
            end
            S_REQ: begin
               if (backoff_request_s) begin
                  br_q <= 1'b0;
                  o_host_bus_grant_n <= 1'b0;
                  st_q <= S_HOLD;
               end else if (own) begin
                  cnt_q <= {4'h0, wait_ld};
                  slow_q_x <= use_slow;
                  o_addr <= cur_addr; // RULE_01
                  o_rd_n <= i_tr_write;
                  o_wr_n <= !i_tr_write;
                  o_data_oe <= i_tr_write;
                  // In 64-bit mode single words ride the half that matches their address parity; in 32-bit mode they ride the low half.
                  if (bus64 && i_tr_dual) begin
                     o_data <= i_tr_wdata;
                  end else if (bus64 && cur_addr[0]) begin
                     o_data <= {i_tr_wdata[31:0], 32'h0000_0000}; // RULE_02
                  end else begin
                     o_data <= {32'h0000_0000, i_tr_wdata[31:0]};
                  end
                  o_msh_n <= !host_rgn; // RULE_04
                  o_ms_n <= ms_rgn ? {~i_tr_addr[`EBH_MS_BANK], i_tr_addr[`EBH_MS_BANK]} : 2'h3;
                  o_msd_n <= sd_rgn ? ~(4'h1 << i_tr_addr[`EBH_SD_BANK]) : 4'hF;
                  st_q <= S_XFER; // RULE_03
               end
            end
            S_XFER: begin
               if (backoff_request_s) begin
                  // The abandoned request stays pending and is retried later.
                  o_rd_n <= 1'b1; // RULE_08
                  o_wr_n <= 1'b1;
                  o_data_oe <= 1'b0;
                  o_ms_n <= 2'h3;
                  o_msd_n <= 4'hF;
                  o_msh_n <= 1'b1;
                  br_q <= 1'b0;
                  o_host_bus_grant_n <= 1'b0;
                  st_q <= S_HOLD;
               end else if (cnt_q != 8'h00) begin
                  cnt_q <= cnt_q - 8'h01;
               end else if (!slow_q_x || !ack_s) begin
                  if (bus64 && i_tr_dual) begin
                     o_tr_rdata <= data_s; // RULE_13
                  end else if (bus64 && o_addr[0]) begin
                     o_tr_rdata[31:0] <= data_s[63:32];
                  end else if (beat_q) begin
                     o_tr_rdata[63:32] <= data_s[31:0];
                  end else begin
                     o_tr_rdata[31:0] <= data_s[31:0];
                  end
                  if (i_tr_dual && !bus64 && !beat_q) begin
                     beat_q <= 1'b1;
                     o_addr <= o_addr + 32'h0000_0001;
                     o_data <= {32'h0000_0000, i_tr_wdata[63:32]};
                     cnt_q <= {4'h0, wait_ld};
                  end else begin
                     o_rd_n <= 1'b1;
                     o_wr_n <= 1'b1;
                     o_data_oe <= 1'b0;
                     o_ms_n <= 2'h3;
                     o_msd_n <= 4'hF;
                     o_msh_n <= 1'b1;
                     o_tr_done <= 1'b1;
                     cnt_q <= {4'h0, cfg[`EBH_CFG_IDLE]}; // RULE_06
                     st_q <= S_GAP;
                  end
               end
            end
            S_GAP: begin
               if (cnt_q != 8'h00) begin
                  cnt_q <= cnt_q - 8'h01;
               end else begin
                  br_q <= lock; // RULE_11
                  st_q <= S_IDLE;
               end
            end
            S_HOLD: begin
               // Host owns the bus; it may only use the pipelined protocol here.
               if (hwr_s) begin
                  o_imem_we <= 1'b1; // RULE_05
                  o_imem_addr <= beat_addr; // RULE_07
                  o_imem_data <= data_s;
                  o_imem_wen <= bus64 ? 2'h3 : 2'h1;
                  burst_addr_q <= beat_addr + (bus64 ? 32'h0000_0002 : 32'h0000_0001); // RULE_20
                  burst_q <= burst_continue_s; // RULE_07
               end
               if (!hbr_s && !backoff_request_s) begin
                  burst_q <= 1'b0;
                  o_host_bus_grant_n <= 1'b1;
                  st_q <= S_IDLE;
               end
            end
            default: st_q <= S_IDLE;
         endcase
      end
   end

   // Configuration slave: one wait state, the access commits when waitrequest is low.
   wire av_req = i_avs_read | i_avs_write;
   reg [31:0] rd_mux;
   always @* begin
      if (i_avs_address == `EBH_REG_CTRL) begin
         rd_mux = {28'h0000000, ctrl_q};
      end else if (i_avs_address == `EBH_REG_PIPE) begin
         rd_mux = {20'h00000, pipe_q};
      end else if (i_avs_address == `EBH_REG_SLOW) begin
         rd_mux = {20'h00000, slow_q};
      end else if (i_avs_address == `EBH_REG_FAIR) begin
         rd_mux = {24'h000000, fair_q};
      end else if (i_avs_address == `EBH_REG_SDRC) begin
         rd_mux = {30'h00000000, sdrc_q};
      end else if (i_avs_address == `EBH_REG_STAT) begin
         rd_mux = {2'h0, last_q, yield_q, own, boot_done_q, backoff_request_s, st_q, boot_words_q};
      end else if (i_avs_address == `EBH_REG_BADR) begin
         rd_mux = burst_addr_q;
      end else begin
         rd_mux = 32'h0000_0000;
      end
   end

   always @(posedge i_clk_sys or posedge i_rst) begin
      if (i_rst) begin
         o_avs_waitrequest <= 1'b1;
         o_avs_readdata <= 32'h0000_0000;
         ctrl_q <= `EBH_CTRL_RST;
         pipe_q <= `EBH_PIPE_RST;
         slow_q <= `EBH_SLOW_RST;
         fair_q <= `EBH_FAIR_RST;
         sdrc_q <= `EBH_SDRC_RST;
      end else begin
         o_avs_waitrequest <= !(av_req && o_avs_waitrequest);
         if (av_req && o_avs_waitrequest) begin
            o_avs_readdata <= i_avs_read ? rd_mux : 32'h0000_0000;
         end
         if (i_avs_write && !o_avs_waitrequest) begin
            if (i_avs_address == `EBH_REG_CTRL) begin
               ctrl_q <= i_avs_writedata[3:0];
            end else if (i_avs_address == `EBH_REG_PIPE) begin
               pipe_q <= i_avs_writedata[11:0];
            end else if (i_avs_address == `EBH_REG_SLOW) begin
               slow_q <= i_avs_writedata[11:0];
            end else if (i_avs_address == `EBH_REG_FAIR) begin
               fair_q <= i_avs_writedata[7:0];
            end else if (i_avs_address == `EBH_REG_SDRC) begin
               sdrc_q <= i_avs_writedata[1:0];
            end
         end
      end
   end
endmodule // ebh_port
`default_nettype wire

// ### include/ebh_consts.vh
`ifndef EBH_CONSTS_VH
`define EBH_CONSTS_VH
// Register byte offsets on the configuration bus.
`define EBH_REG_CTRL 5'h00
`define EBH_REG_PIPE 5'h04
`define EBH_REG_SLOW 5'h08
`define EBH_REG_FAIR 5'h0C
`define EBH_REG_SDRC 5'h10
`define EBH_REG_STAT 5'h14
`define EBH_REG_BADR 5'h18
// Control register fields.
`define EBH_CTRL_BUS64 0
`define EBH_CTRL_SLOW 1
`define EBH_CTRL_LOCK 2
`define EBH_CTRL_FAIR 3
`define EBH_CTRL_RST 4'h9
// Protocol parameter fields: idle cycles, pipe depth, internal wait cycles.
`define EBH_CFG_IDLE 3:0
`define EBH_CFG_DEPTH 7:4
`define EBH_CFG_WAIT 11:8
`define EBH_PIPE_RST 12'h021
`define EBH_SLOW_RST 12'h201
`define EBH_FAIR_RST 8'h10
`define EBH_SDRC_RST 2'h3
// Address regions and bank fields.
`define EBH_HOST_BIT 31
`define EBH_MS_REGION 4'h3
`define EBH_SD_REGION 4'h4
`define EBH_REGION 30:28
`define EBH_SD_BANK 27:26
`define EBH_MS_BANK 27
// Boot memory.
`define EBH_BOOT_WAIT 8'h10
`define EBH_BOOT_ABITS 24
`endif

// ### verification/ebh_bus_model.sv
`timescale 1ns/1ps
`default_nettype none
module ebh_bus_model (
   // Clock
   input wire logic i_clk_sys,
   // Pins driven by the port
   input wire logic [31:0] i_addr,
   input wire logic i_rd_n,
   input wire logic i_wr_n,
   input wire logic [63:0] i_wdata,
   input wire logic i_oe,
   input wire logic [7:0] i_sel_n,
   // Response control
   input wire logic [7:0] i_ack_dly,
   // Far side pins
   output logic [63:0] o_data,
   output logic o_ack,
   output logic [63:0] o_last_wdata
);
   logic [31:0] lat_q = 32'h0;
   logic boot_q = 1'b0;
   logic [3:0] hold_q = 4'h0;
   logic [7:0] wait_q = 8'h00;
   logic [63:0] drv_q = 64'h0;
   logic [63:0] pat;
   assign pat = boot_q ? {8{lat_q[7:0] ^ 8'h3C}}
      : {lat_q | 32'h1, lat_q} ^ {2{32'h5A5A5A5A}};
   // A released bus toggles so that a stale sample never passes for fresh data.
   assign o_data = (hold_q != 4'h0) ? pat : ~drv_q;
   // Acknowledge is low-active with a pull-up and comes after the chosen delay.
   assign o_ack = !((!i_rd_n || !i_wr_n) && wait_q >= i_ack_dly);
   always @(posedge i_clk_sys) begin
      drv_q <= o_data;
      if (i_sel_n != 8'hFF) begin
         lat_q <= i_addr;
         boot_q <= !i_sel_n[0];
         hold_q <= 4'h6;
      end else if (hold_q != 4'h0) begin
         hold_q <= hold_q - 4'h1;
      end
      if (i_rd_n && i_wr_n) begin
         wait_q <= 8'h00;
      end else if (wait_q != 8'hFF) begin
         wait_q <= wait_q + 8'h01;
      end
      if (i_oe) begin
         o_last_wdata <= i_wdata;
      end
   end
endmodule // ebh_bus_model
`default_nettype wire

// ### verification/ebh_port_props.sv
`timescale 1ns/1ps
`default_nettype none
module ebh_port_props (
   // Clock and reset
   input wire logic i_clk_sys,
   input wire logic i_rst,
   // Watched pins
   input wire logic i_avs_read,
   input wire logic i_avs_write,
   input wire logic o_avs_waitrequest,
   input wire logic i_tr_valid,
   input wire logic o_tr_done,
   input wire logic o_data_oe,
   input wire logic o_rd_n,
   input wire logic o_wr_n,
   input wire logic [1:0] o_ms_n,
   input wire logic [3:0] o_msd_n,
   input wire logic o_msh_n,
   input wire logic o_boot_memory_select_n,
   input wire logic o_br_n,
   input wire logic i_hbr_n,
   input wire logic o_host_bus_grant_n
);
   default clocking cb @(posedge i_clk_sys); endclocking
   default disable iff (i_rst);
   wire [7:0] sels = {o_ms_n, o_msd_n, o_msh_n, o_boot_memory_select_n};
   AST_AVS_ANSWER: assert property ((i_avs_read || i_avs_write) && o_avs_waitrequest
      |=> !o_avs_waitrequest) else $error("config answer late");
   AST_AVS_STAND: assert property (!o_avs_waitrequest |=> o_avs_waitrequest)
      else $error("config answer held too long");
   AST_RDWR_EXCL: assert property (o_rd_n || o_wr_n)
      else $error("read and write strobes both low");
   AST_ONE_SELECT: assert property ($countones(~sels) <= 1)
      else $error("more than one bank select low");
   AST_DONE_PULSE: assert property (o_tr_done |=> !o_tr_done)
      else $error("done longer than one cycle");
   AST_DONE_CAUSE: assert property (o_tr_done |-> i_tr_valid)
      else $error("done without a request");
   AST_BR_CAUSE: assert property ($fell(o_br_n) |-> i_tr_valid)
      else $error("bus request without a transfer");
   AST_GRANT_CAUSE: assert property ($fell(o_host_bus_grant_n) |-> !$past(i_hbr_n, 2))
      else $error("grant without host request");
   AST_GRANT_FREE: assert property (!o_host_bus_grant_n |-> !o_data_oe && o_rd_n && o_wr_n)
      else $error("bus driven while host granted");
   AST_BOOT_HOLD: assert property ($fell(o_boot_memory_select_n)
      |-> !o_boot_memory_select_n [*8])
      else $error("boot select too short");
   cover property (o_tr_done);
   cover property ($fell(o_host_bus_grant_n));
   cover property ($fell(o_boot_memory_select_n));
endmodule // ebh_port_props
bind ebh_port ebh_port_props ebh_port_props_i (.i_clk_sys, .i_rst, .i_avs_read, .i_avs_write,
   .o_avs_waitrequest, .i_tr_valid, .o_tr_done, .o_data_oe, .o_rd_n, .o_wr_n, .o_ms_n,
   .o_msd_n, .o_msh_n, .o_boot_memory_select_n, .o_br_n, .i_hbr_n, .o_host_bus_grant_n);
`default_nettype wire

// ### verification/ebh_port_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module ebh_port_tb_top;
   logic i_clk_sys = 1'b0, i_rst = 1'b1;
   logic [4:0] i_avs_address = 5'h00;
   logic i_avs_read = 1'b0, i_avs_write = 1'b0, o_avs_waitrequest;
   logic [31:0] i_avs_writedata = 32'h0, o_avs_readdata, o_addr, o_imem_addr;
   logic i_tr_valid = 1'b0, i_tr_write = 1'b0, i_tr_dual = 1'b0, o_tr_done;
   logic [31:0] i_tr_addr = 32'h0, i_hst_addr = 32'h0;
   logic [63:0] i_tr_wdata = 64'h0, o_tr_rdata, i_data, o_data, o_imem_data, last_wd;
   logic o_data_oe, o_rd_n, o_wr_n, i_ack, o_msh_n, o_boot_memory_select_n, o_br_n;
   logic [1:0] o_ms_n, o_imem_wen;
   logic [3:0] o_msd_n;
   logic [7:0] i_br_n = 8'hFF, ack_dly = 8'h02;
   logic i_hbr_n = 1'b1, i_backoff_request_n = 1'b1, i_burst_continue_n = 1'b1;
   logic i_hst_wr_n = 1'b1, i_boot_strap = 1'b1, o_host_bus_grant_n, o_imem_we;
   logic phase = 1'b0, bms_seen = 1'b0;
   logic [31:0] hq[$];
   logic [31:0] r;
   logic [63:0] q;
   logic [4:0] ra[6] = '{5'h00, 5'h04, 5'h08, 5'h0C, 5'h10, 5'h1C};
   logic [31:0] rv[6] = '{32'h9, 32'h21, 32'h201, 32'h10, 32'h3, 32'h0};
   int fail_count = 0, cmp_count = 0, gap = 0, nboot = 0;
   always #2.5 i_clk_sys = ~i_clk_sys;
   ebh_port #(.BOOT_WORDS(16'h0004)) ebh_port_i (.i_clk_sys, .i_rst, .i_avs_address,
      .i_avs_read, .i_avs_write, .i_avs_writedata, .o_avs_readdata, .o_avs_waitrequest,
      .i_tr_valid, .i_tr_write, .i_tr_dual, .i_tr_addr, .i_tr_wdata, .o_tr_done, .o_tr_rdata,
      .o_addr, .i_data, .o_data, .o_data_oe, .o_rd_n, .o_wr_n, .i_ack, .o_ms_n, .o_msd_n,
      .o_msh_n, .o_boot_memory_select_n, .i_br_n, .o_br_n, .i_hbr_n, .o_host_bus_grant_n,
      .i_backoff_request_n, .i_burst_continue_n, .i_hst_wr_n, .i_hst_addr, .i_boot_strap,
      .o_imem_we, .o_imem_addr, .o_imem_data, .o_imem_wen);
   ebh_bus_model ebh_bus_model_i (.i_clk_sys, .i_addr(o_addr), .i_rd_n(o_rd_n),
      .i_wr_n(o_wr_n), .i_wdata(o_data), .i_oe(o_data_oe),
      .i_sel_n({o_ms_n, o_msd_n, o_msh_n, o_boot_memory_select_n}), .i_ack_dly(ack_dly),
      .o_data(i_data), .o_ack(i_ack), .o_last_wdata(last_wd));
   function automatic logic [63:0] pair(input logic [31:0] a);
      return {a + 32'h1, a} ^ {2{32'h5A5A5A5A}};
   endfunction
   function automatic logic [31:0] bw(input int k);
      for (int i = 0; i < 4; i++) bw[8*i+:8] = 8'(4 * k + i) ^ 8'h3C;
   endfunction
   task automatic chk(input string nm, input logic [63:0] exp, input logic [63:0] got);
      cmp_count++;
      if (got !== exp) begin
         fail_count++;
         $display("[ERR] %s expected %h seen %h", nm, exp, got);
      end
   endtask
   task automatic avs(input logic wr, input logic [4:0] a, input logic [31:0] d);
      @(posedge i_clk_sys);
      i_avs_address <= a;
      i_avs_writedata <= d;
      i_avs_read <= !wr;
      i_avs_write <= wr;
      do @(posedge i_clk_sys); while (o_avs_waitrequest !== 1'b0);
      r = o_avs_readdata;
      i_avs_read <= 1'b0;
      i_avs_write <= 1'b0;
   endtask
   task automatic core(input logic wr, input logic dual, input logic [31:0] a,
      input logic [63:0] d);
      @(posedge i_clk_sys);
      i_tr_valid <= 1'b1;
      i_tr_write <= wr;
      i_tr_dual <= dual;
      i_tr_addr <= a;
      i_tr_wdata <= d;
      do @(posedge i_clk_sys); while (o_tr_done !== 1'b1);
      q = o_tr_rdata;
      i_tr_valid <= 1'b0;
   endtask
   task automatic final_report;
      $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
      if (fail_count == 0 && cmp_count > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   always @(posedge i_clk_sys) begin
      gap++;
      if (o_boot_memory_select_n === 1'b0) bms_seen = 1'b1;
      if (o_imem_we === 1'b1 && !phase) begin
         chk("boot word", bw(nboot), o_imem_wen[1] ? o_imem_data[63:32] : o_imem_data[31:0]);
         chk("boot spacing", 1'b1, gap >= 64);
         gap = 0;
         nboot++;
      end
      if (o_imem_we === 1'b1 && phase) hq.push_back(o_imem_addr);
   end
   initial begin
      repeat (20000) @(posedge i_clk_sys);
      fail_count++;
      final_report();
   end
   initial begin
      repeat (2) @(posedge i_clk_sys);
      i_rst <= 1'b0;
      wait (nboot == 4);
      phase = 1'b1;
      chk("boot select", 1'b1, bms_seen);
      for (int i = 0; i < 6; i++) begin
         avs(1'b0, ra[i], 32'h0);
         chk("register reset", rv[i], r);
      end
      avs(1'b1, 5'h1C, 32'hFFFFFFFF);
      avs(1'b0, 5'h1C, 32'h0);
      chk("unmapped", 32'h0, r);
      avs(1'b1, 5'h04, 32'h132);
      avs(1'b0, 5'h04, 32'h0);
      chk("pipe setting", 32'h132, r);
      avs(1'b1, 5'h00, 32'h8);
      core(1'b0, 1'b1, 32'h30000010, 64'h0);
      chk("dual read 32", pair(32'h30000010), q);
      avs(1'b1, 5'h00, 32'h9);
      core(1'b0, 1'b1, 32'h30000020, 64'h0);
      chk("dual read 64", pair(32'h30000020), q);
      core(1'b1, 1'b0, 32'h30000021, 64'h12345678);
      chk("odd write half", 32'h12345678, last_wd[63:32]);
      core(1'b0, 1'b1, 32'h40000008, 64'h0);
      // Region bits are cut from the SDRAM address pins by the density mask.
      chk("sdram read", pair(32'h00000008), q);
      avs(1'b1, 5'h00, 32'hB);
      ack_dly <= 8'h05;
      core(1'b0, 1'b1, 32'h80000004, 64'h0);
      chk("slow host read", pair(32'h80000004), q);
      ack_dly <= 8'hC8;
      fork
         core(1'b0, 1'b1, 32'h80000010, 64'h0);
         begin
            repeat (20) @(posedge i_clk_sys);
            i_hbr_n <= 1'b0;
            i_backoff_request_n <= 1'b0;
            wait (o_host_bus_grant_n === 1'b0);
            chk("bus released", 2'h3, {o_rd_n, o_wr_n});
            @(posedge i_clk_sys);
            i_hst_addr <= 32'h100;
            i_hst_wr_n <= 1'b0;
            i_burst_continue_n <= 1'b0;
            repeat (3) @(posedge i_clk_sys);
            i_hst_wr_n <= 1'b1;
            i_burst_continue_n <= 1'b1;
            repeat (8) @(posedge i_clk_sys);
            chk("burst beats", 3, hq.size());
            for (int i = 0; i < 3; i++) chk("burst addr", 32'h100 + 2 * i, hq[i]);
            ack_dly <= 8'h03;
            i_hbr_n <= 1'b1;
            i_backoff_request_n <= 1'b1;
         end
      join
      chk("retried read", pair(32'h80000010), q);
      avs(1'b0, 5'h18, 32'h0);
      chk("next burst address", 32'h106, r);
      final_report();
   end
endmodule // ebh_port_tb_top
`default_nettype wire
